// >>> t1_error_counter_update_tb_top.sv
// self-checking bench for the framer error counter block
// assumes tecu_pkg and tecu_counter compiled first; bench drives all ports
`timescale 1ns/1ns
module t1_error_counter_update_tb_top;
  logic       clock;
  logic       srst;
  logic       cs;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata_q;
  logic       e1_mode;
  logic       b8zs_enable;
  logic [6:0] ev;
  logic       lof;
  logic       framer_tick;
  logic       glatch;
  logic       tclr;
  logic       one_second_tick;
  logic       timer_event_q;
  int         errors;
  int         n_checks;
  int         cycles;
  int         seed;

  // short interval counts keep the run brief
  tecu_counter #(.SECOND_CYCLES(100), .T1_CYCLES(20), .E1_CYCLES(30))
    i_tecu_counter (
    .clock(clock), .srst(srst), .cs(cs), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata_q(rdata_q), .e1_mode(e1_mode),
    .b8zs_enable(b8zs_enable), .bpv_event(ev[6]), .bpv_in_codeword(ev[5]),
    .ft_error(ev[4]), .fs_error(ev[3]), .oos_multiframe(ev[2]),
    .bit_valid(ev[1]), .bit_is_zero(ev[0]), .receive_loss_of_frame(lof),
    .framer_one_tick(framer_tick), .global_counter_latch(glatch),
    .timer_event_clear(tclr), .one_second_tick(one_second_tick),
    .timer_event_q(timer_event_q));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      errors = errors + 1;
      $display("Error at %0t: run timed out", $time);
      complete_run;
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_int(input int got, input int exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: period %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cs = 1'b1;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clock);
    #1;
    cs = 1'b0;
    wr_en = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cs = 1'b1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clock);
    #1;
    cs = 1'b0;
    rd_en = 1'b0;
    @(posedge clock);
    #1;
    d = rdata_q;
  endtask

  task automatic send(input logic [6:0] v);
    ev = v;
    @(posedge clock);
    #1;
  endtask

  // clears the flag, then counts cycles until it sets again
  task automatic wait_ev(output int n);
    tclr = 1'b1;
    @(posedge clock);
    #1;
    tclr = 1'b0;
    n = 1;
    while (timer_event_q !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask

  function automatic logic [47:0] exp_counts(int nb, int nc, int nf,
      int ns, int nm, int zr, logic fsb, logic oof, logic exz, logic lf,
      logic b8);
    int lcv;
    int pcv;
    int oos;
    lcv = nb - nc + int'(exz && zr >= (b8 ? 8 : 16));
    pcv = lf ? 0 : nf + (fsb ? ns : 0);
    oos = oof ? nm : (lf ? 0 : nf);
    return {16'(lcv), 16'(pcv), 16'(oos)};
  endfunction

  initial begin
    logic [7:0]  d;
    logic [7:0]  cfg;
    logic [31:0] r;
    logic [47:0] e;
    logic        src, fsb, oof, exz, b8, c;
    int          n, m, nb, nc, nf, ns, nm, zr;
    int          zt[4];
    int          pt[3];
    seed = 32'hcc75;
    zt = '{15, 16, 7, 8};
    pt = '{20, 30, 100};
    errors = 0;
    n_checks = 0;
    cycles = 0;
    {srst, cs, wr_en, rd_en, addr, wdata, e1_mode, b8zs_enable} = '0;
    {ev, lof, framer_tick, glatch, tclr} = '0;
    srst = 1'b1;
    repeat (12) @(posedge clock);
    #1;
    srst = 1'b0;
    send(7'h00);
    rd(8'h50, d);
    chk_byte(d, 8'h00);
    rd(tecu_pkg::ADDR_ERR_CFG, d);
    chk_byte(d, tecu_pkg::ERR_CFG_RESET);
    wr(8'h50, 8'hff);
    rd(8'h50, d);
    chk_byte(d, 8'h00);
    rd(8'h60, d);
    chk_byte(d, 8'h00);
    wr(tecu_pkg::ADDR_ERR_CFG, 8'h5a);
    rd(tecu_pkg::ADDR_ERR_CFG, d);
    chk_byte(d, 8'h5a);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      {src, fsb, oof, exz, lof, b8} = r[5:0];
      nb = int'(r[8:6]);
      nf = int'(r[10:9]);
      ns = int'(r[12:11]);
      nm = int'(r[14:13]);
      zr = int'(r[19:15]);
      if (i < 4) begin
        zr = zt[i];
        b8 = i[1];
        exz = 1'b1;
        src = i[0];
        lof = i[0];
        fsb = i[1];
        oof = !i[1];
        nf += 1;
        ns += 1;
        nm += 1;
      end
      b8zs_enable = b8;
      cfg = {1'b0, src, 3'b001, fsb, oof, exz};
      wr(tecu_pkg::ADDR_ERR_CFG, cfg);
      nc = 0;
      for (int k = 0; k < nb; k++) begin
        c = b8 & r[20+k];
        nc += int'(c);
        send({1'b1, c, 5'h00});
      end
      repeat (nf) send(7'h10);
      repeat (ns) send(7'h08);
      repeat (nm) send(7'h04);
      repeat (zr) send(7'h03);
      send(7'h02);
      send(7'h00);
      if (src) begin
        glatch = 1'b1;
        send(7'h00);
        glatch = 1'b0;
      end else begin
        wr(tecu_pkg::ADDR_ERR_CFG, cfg | 8'h20);
      end
      repeat (6250) @(posedge clock);
      #1;
      e = exp_counts(nb, nc, nf, ns, nm, zr, fsb, oof, exz, lof, b8);
      for (int a = 0; a < 6; a++) begin
        rd(8'h50 + 8'(a), d);
        chk_byte(d, e[47-8*a -: 8]);
      end
    end
    wr(tecu_pkg::ADDR_ERR_CFG, 8'h08);
    repeat (300) send(7'h40);
    send(7'h00);
    wr(tecu_pkg::ADDR_ERR_CFG, 8'h28);
    repeat (6250) @(posedge clock);
    #1;
    rd(tecu_pkg::ADDR_LCV_HIGH, d);
    chk_byte(d, 8'h01);
    rd(tecu_pkg::ADDR_LCV_LOW, d);
    chk_byte(d, 8'h2c);
    $display("test manual latch done");
    lof = 1'b0;
    wr(tecu_pkg::ADDR_ERR_CFG, 8'h10);
    for (int j = 0; j < 3; j++) begin
      e1_mode = j[0];
      if (j == 2) begin
        wr(tecu_pkg::ADDR_ERR_CFG, 8'h00);
      end
      wait_ev(n);
      wait_ev(n);
      chk_int(n, pt[j]);
      r = $random(seed);
      m = 1 + int'(r[1:0]);
      repeat (m) send(7'h40);
      send(7'h00);
      wait_ev(n);
      rd(tecu_pkg::ADDR_LCV_LOW, d);
      chk_byte(d, 8'(m));
    end
    $display("test timed update done");
    wr(tecu_pkg::ADDR_ERR_CFG, 8'h80);
    repeat (3) send(7'h40);
    framer_tick = 1'b1;
    send(7'h00);
    framer_tick = 1'b0;
    repeat (2) send(7'h40);
    send(7'h00);
    repeat (110) send(7'h00);
    rd(tecu_pkg::ADDR_LCV_LOW, d);
    chk_byte(d, 8'h03);
    framer_tick = 1'b1;
    send(7'h00);
    framer_tick = 1'b0;
    rd(tecu_pkg::ADDR_LCV_LOW, d);
    chk_byte(d, 8'h02);
    $display("test second source done");
    srst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    srst = 1'b0;
    chk_byte({7'h00, timer_event_q}, 8'h00);
    rd(tecu_pkg::ADDR_LCV_LOW, d);
    chk_byte(d, 8'h00);
    rd(tecu_pkg::ADDR_ERR_CFG, d);
    chk_byte(d, tecu_pkg::ERR_CFG_RESET);
    m = 0;
    while (one_second_tick !== 1'b1 && m < 300) begin
      @(posedge clock);
      #1;
      m++;
    end
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (one_second_tick !== 1'b1 && n < 300);
    chk_int(n, 100);
    $display("test reset and second tick done");
    complete_run;
  end
endmodule

// >>> tecu_counter.sv
// framer receive error counters with timed or manual update
// assumes line events are one-cycle pulses synchronous to clock
// Functional notes
// - timed mode latches on own second tick, or framer one tick if select set
// - manual latch comes from own latch bit, or global latch if select set
// - rising manual latch bit loads registers next cycle and clears counts
// - t1 timed update every second, or every 42 ms when interval bit set
// - e1 timed update every second, or every 62.5 ms when interval bit set
// - accumulation mode bit picks timed (0) or manual (1) update
// - path counter counts ft errors, plus fs errors when report bit set
// - oos counter counts framing errors, or out-of-sync multiframes
// - line counter counts bipolar violations, plus excess zeros if enabled
// - without b8zs an excess zero event is a run of 16 zeros
// - with b8zs an excess zero event is a run of 8 zeros
// - b8zs codeword violations are not counted when b8zs decoding is on
// - line counter keeps counting during loss of frame
// - line count is 16 bits, high byte first register, low byte second
// - timer event flag sets every time the update interval elapses
`timescale 1ns/1ns
module tecu_counter #(
  parameter int unsigned SECOND_CYCLES = int'(tecu_pkg::SECOND_CYCLES),
  parameter int unsigned T1_CYCLES     = int'(tecu_pkg::T1_CYCLES),
  parameter int unsigned E1_CYCLES     = int'(tecu_pkg::E1_CYCLES)
) (
  input  wire logic       clock,                // 25 mhz clock
  input  wire logic       srst,                 // sync reset, high
  input  wire logic       cs,                   // register port select
  input  wire logic       wr_en,                // write strobe
  input  wire logic       rd_en,                // read strobe
  input  wire logic [7:0] addr,                 // register offset
  input  wire logic [7:0] wdata,                // write data
  output logic      [7:0] rdata_q,              // read data, next cycle
  input  wire logic       e1_mode,              // 1 = e1, 0 = t1
  input  wire logic       b8zs_enable,          // receive b8zs decoding
  input  wire logic       bpv_event,            // bipolar violation pulse
  input  wire logic       bpv_in_codeword,      // bpv part of b8zs word
  input  wire logic       bit_valid,            // received bit strobe
  input  wire logic       bit_is_zero,          // received bit was zero
  input  wire logic       ft_error,             // ft or fps bit error
  input  wire logic       fs_error,             // fs bit error
  input  wire logic       oos_multiframe,       // multiframe out of sync
  input  wire logic       receive_loss_of_frame,// frame sync lost
  input  wire logic       framer_one_tick,      // framer one second tick
  input  wire logic       global_counter_latch, // global latch level
  input  wire logic       timer_event_clear,    // clears timer flag
  output logic            one_second_tick,      // own second pulse
  output logic            timer_event_q         // latched timer event
);
  localparam int N = tecu_pkg::NUM_CNT;

  tecu_tick_if tick ();

  tecu_timebase #(
    .SECOND_CYCLES (SECOND_CYCLES),
    .T1_CYCLES     (T1_CYCLES),
    .E1_CYCLES     (E1_CYCLES)
  ) u_timebase (
    .clock (clock),
    .srst  (srst),
    .tb    (tick)
  );

  assign tick.e1_mode    = e1_mode;
  assign one_second_tick = tick.one_sec_tick;

  logic [7:0]  cfg_q;
  logic [7:0]  cfg_d;
  logic        latch_prev_q;
  logic        glb_prev_q;
  logic [4:0]  zrun_q;
  logic [4:0]  zrun_d;
  logic        timer_q;
  logic        timer_d;
  logic [7:0]  rdata_d;
  logic [15:0] cnt_q  [N];
  logic [15:0] cnt_d  [N];
  logic [15:0] held_q [N];
  logic [15:0] held_d [N];
  logic [N-1:0] inc;

  logic cfg_wr;
  logic manual;
  logic sec_tick;
  logic interval_tick;
  logic latch_rise;
  logic glb_rise;
  logic update_timed;
  logic update_manual;
  logic update;
  logic bpv_counted;
  logic zero_event;
  logic [4:0] zero_limit;

  // control and update selection
  always_comb begin
    cfg_wr   = cs && wr_en && (addr == tecu_pkg::ADDR_ERR_CFG);
    cfg_d    = cfg_wr ? wdata : cfg_q;
    manual   = cfg_q[tecu_pkg::BIT_ACCUM_MODE];
    sec_tick = cfg_q[tecu_pkg::BIT_ONE_SEC_SRC] ? framer_one_tick
                                                : tick.one_sec_tick;
    interval_tick = cfg_q[tecu_pkg::BIT_INTERVAL_SEL] ? tick.short_tick
                                                      : sec_tick;
    latch_rise = cfg_q[tecu_pkg::BIT_MAN_LATCH] && !latch_prev_q;
    glb_rise   = global_counter_latch && !glb_prev_q;
    update_timed  = !manual && interval_tick;
    update_manual = manual && (cfg_q[tecu_pkg::BIT_MAN_LATCH_SRC]
                               ? glb_rise : latch_rise);
    update  = update_timed || update_manual;
    // set wins over a clear in the same cycle
    timer_d = interval_tick ? 1'b1
            : (timer_event_clear ? 1'b0 : timer_q);
  end

  // line code violation qualification
  always_comb begin
    zero_limit = b8zs_enable ? tecu_pkg::ZERO_RUN_B8ZS
                             : tecu_pkg::ZERO_RUN_PLAIN;
    zrun_d = zrun_q;
    if (bit_valid) begin
      if (!bit_is_zero) begin
        zrun_d = '0;
      end else if (zrun_q != tecu_pkg::ZERO_RUN_PLAIN) begin
        zrun_d = zrun_q + 1'b1;
      end
    end
    // one event per run, when the run first reaches the limit
    zero_event = bit_valid && bit_is_zero && (zrun_q + 1'b1 == zero_limit);
    bpv_counted = bpv_event && !(b8zs_enable && bpv_in_codeword);
    // no loss of frame gating on the line counter
    inc[tecu_pkg::CNT_LCV] = bpv_counted ||
      (cfg_q[tecu_pkg::BIT_EXCESS_ZERO] && zero_event);
    inc[tecu_pkg::CNT_PCV] = !receive_loss_of_frame && (ft_error ||
      (cfg_q[tecu_pkg::BIT_FS_REPORT] && fs_error));
    inc[tecu_pkg::CNT_OOS] = cfg_q[tecu_pkg::BIT_OOS_FUNC]
      ? oos_multiframe : (!receive_loss_of_frame && ft_error);
  end

  // running counts and host-visible copies
  for (genvar i = 0; i < N; i++) begin : g_cnt
    always_comb begin
      if (update) begin
        cnt_d[i]  = {15'h0000, inc[i]};
        held_d[i] = cnt_q[i];
      end else begin
        cnt_d[i]  = (cnt_q[i] == tecu_pkg::CNT_MAX) ? cnt_q[i]
                  : cnt_q[i] + {15'h0000, inc[i]};
        held_d[i] = held_q[i];
      end
    end
    always_ff @(posedge clock) begin
      if (srst) begin
        cnt_q[i]  <= '0;
        held_q[i] <= '0;
      end else begin
        cnt_q[i]  <= cnt_d[i];
        held_q[i] <= held_d[i];
      end
    end
  end

  // register read port
  always_comb begin
    rdata_d = rdata_q;
    if (cs && rd_en) begin
      case (addr)
        tecu_pkg::ADDR_LCV_HIGH:
          rdata_d = held_q[tecu_pkg::CNT_LCV][15:8];
        tecu_pkg::ADDR_LCV_LOW:
          rdata_d = held_q[tecu_pkg::CNT_LCV][7:0];
        tecu_pkg::ADDR_PCV_HIGH: rdata_d = held_q[tecu_pkg::CNT_PCV][15:8];
        tecu_pkg::ADDR_PCV_LOW:  rdata_d = held_q[tecu_pkg::CNT_PCV][7:0];
        tecu_pkg::ADDR_OOS_HIGH: rdata_d = held_q[tecu_pkg::CNT_OOS][15:8];
        tecu_pkg::ADDR_OOS_LOW:  rdata_d = held_q[tecu_pkg::CNT_OOS][7:0];
        tecu_pkg::ADDR_ERR_CFG:  rdata_d = cfg_q;
        default:                 rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_q       <= tecu_pkg::ERR_CFG_RESET;
      latch_prev_q <= 1'b0;
      glb_prev_q   <= 1'b0;
      zrun_q      <= '0;
      timer_q     <= 1'b0;
      rdata_q     <= 8'h00;
    end else begin
      cfg_q       <= cfg_d;
      latch_prev_q <= cfg_q[tecu_pkg::BIT_MAN_LATCH];
      glb_prev_q   <= global_counter_latch;
      zrun_q      <= zrun_d;
      timer_q     <= timer_d;
      rdata_q     <= rdata_d;
    end
  end

  assign timer_event_q = timer_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_latch_write;
    cfg_wr && wdata[tecu_pkg::BIT_MAN_LATCH] &&
      wdata[tecu_pkg::BIT_ACCUM_MODE] &&
      !wdata[tecu_pkg::BIT_MAN_LATCH_SRC] &&
      !cfg_q[tecu_pkg::BIT_MAN_LATCH];
  endsequence
  sequence s_load;
    held_q[tecu_pkg::CNT_LCV] == $past(cnt_q[tecu_pkg::CNT_LCV]);
  endsequence

  a_timed_own_sec: assert property (!manual &&
    !cfg_q[tecu_pkg::BIT_INTERVAL_SEL] && !cfg_q[tecu_pkg::BIT_ONE_SEC_SRC]
    |-> update == tick.one_sec_tick)
    else $error("timed update not following own second tick");
  a_manual_global: assert property (manual &&
    cfg_q[tecu_pkg::BIT_MAN_LATCH_SRC] && global_counter_latch &&
    !glb_prev_q |-> update)
    else $error("global latch edge did not update");
  a_manual_edge: assert property (s_latch_write |=> update ##1
    !update ##0 s_load)
    else $error("manual latch did not load next cycle");
  a_manual_no_tick: assert property (manual && !update_manual
    |-> !update)
    else $error("timed tick updated in manual mode");
  a_load_counts: assert property (update |=>
    cnt_q[tecu_pkg::CNT_LCV] == {15'h0000, $past(inc[tecu_pkg::CNT_LCV])})
    else $error("running count not restarted on update");
  a_hold_copy: assert property (update |=> s_load)
    else $error("held count not loaded");
  a_b8zs_mask: assert property (b8zs_enable && bpv_in_codeword &&
    !zero_event |-> !inc[tecu_pkg::CNT_LCV])
    else $error("b8zs codeword counted");
  a_lcv_in_lof: assert property (receive_loss_of_frame &&
    bpv_event && !b8zs_enable |-> inc[tecu_pkg::CNT_LCV])
    else $error("line counter gated by loss of frame");
  a_pcv_lof_gate: assert property (receive_loss_of_frame
    |-> !inc[tecu_pkg::CNT_PCV])
    else $error("path counter counted during loss of frame");
  a_zero_gate: assert property (!cfg_q[tecu_pkg::BIT_EXCESS_ZERO] &&
    !bpv_event |-> !inc[tecu_pkg::CNT_LCV])
    else $error("excess zeros counted while disabled");
  a_zero_run8: assert property (b8zs_enable && bit_valid &&
    bit_is_zero && zrun_q == 5'h07 |-> zero_event)
    else $error("eight-zero run missed");
  a_timer_set: assert property (interval_tick |=> timer_q [*2] or
    (timer_q ##1 !timer_q))
    else $error("timer flag not set on interval");
endmodule

// >>> tecu_pkg.sv
// error counter update block: shared constants
// assumes one 25 MHz clock and an 8-bit register port per framer
package tecu_pkg;
  // timing figures in their own units and derived cycle counts
  localparam longint CLOCK_HZ       = 25000000;
  localparam longint ONE_SECOND_US  = 1000000;
  localparam longint T1_INTERVAL_US = 42000;
  localparam longint E1_INTERVAL_US = 62500;
  localparam longint SECOND_CYCLES  = CLOCK_HZ * ONE_SECOND_US / 1000000;
  localparam longint T1_CYCLES      = CLOCK_HZ * T1_INTERVAL_US / 1000000;
  localparam longint E1_CYCLES      = CLOCK_HZ * E1_INTERVAL_US / 1000000;
  localparam int     TB_W           = 25;

  // register offsets on the framer page
  localparam logic [7:0] ADDR_LCV_HIGH  = 8'h50;
  localparam logic [7:0] ADDR_LCV_LOW   = 8'h51;
  localparam logic [7:0] ADDR_PCV_HIGH  = 8'h52;
  localparam logic [7:0] ADDR_PCV_LOW   = 8'h53;
  localparam logic [7:0] ADDR_OOS_HIGH  = 8'h54;
  localparam logic [7:0] ADDR_OOS_LOW   = 8'h55;
  localparam logic [7:0] ADDR_ERR_CFG   = 8'h86;
  localparam logic [7:0] ERR_CFG_RESET  = 8'h00;

  // error_counter_config fields
  localparam int BIT_ONE_SEC_SRC   = 7;
  localparam int BIT_MAN_LATCH_SRC = 6;
  localparam int BIT_MAN_LATCH     = 5;
  localparam int BIT_INTERVAL_SEL  = 4;
  localparam int BIT_ACCUM_MODE    = 3;
  localparam int BIT_FS_REPORT     = 2;
  localparam int BIT_OOS_FUNC      = 1;
  localparam int BIT_EXCESS_ZERO   = 0;

  // counters
  localparam int          CNT_W          = 16;
  localparam int          NUM_CNT        = 3;
  localparam int          CNT_LCV        = 0;
  localparam int          CNT_PCV        = 1;
  localparam int          CNT_OOS        = 2;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  localparam logic [4:0]  ZERO_RUN_PLAIN = 5'h10;
  localparam logic [4:0]  ZERO_RUN_B8ZS  = 5'h08;
endpackage

// >>> tecu_tick_if.sv
// tick bundle between the time base and the counter block
// assumes both ends share one clock
`timescale 1ns/1ns
interface tecu_tick_if;
  logic e1_mode;       // 1 = e1 interval length
  logic one_sec_tick;  // own one-second pulse
  logic short_tick;    // 42 ms / 62.5 ms pulse
  modport timebase (input e1_mode, output one_sec_tick, output short_tick);
  modport user (output e1_mode, input one_sec_tick, input short_tick);
endinterface

// >>> tecu_timebase.sv
// one-second and short-interval pulse generator
// assumes a free running clock; pulses are one cycle wide
`timescale 1ns/1ns
module tecu_timebase #(
  parameter int unsigned SECOND_CYCLES = 25000000,
  parameter int unsigned T1_CYCLES     = 1050000,
  parameter int unsigned E1_CYCLES     = 1562500
) (
  input  wire logic  clock,  // system clock
  input  wire logic  srst,   // synchronous reset, high
  tecu_tick_if.timebase tb   // tick bundle
);
  localparam int W = tecu_pkg::TB_W;
  localparam logic [W-1:0] SEC_LAST = W'(SECOND_CYCLES - 1);
  localparam logic [W-1:0] T1_LAST  = W'(T1_CYCLES - 1);
  localparam logic [W-1:0] E1_LAST  = W'(E1_CYCLES - 1);

  logic [W-1:0] sec_q;
  logic [W-1:0] sec_d;
  logic [W-1:0] ivl_q;
  logic [W-1:0] ivl_d;
  logic [W-1:0] ivl_last;

  always_comb begin
    ivl_last = tb.e1_mode ? E1_LAST : T1_LAST;
    sec_d    = (sec_q == SEC_LAST) ? '0 : sec_q + 1'b1;
    // >= restarts cleanly if the mode shortens mid interval
    ivl_d    = (ivl_q >= ivl_last) ? '0 : ivl_q + 1'b1;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sec_q <= '0;
      ivl_q <= '0;
    end else begin
      sec_q <= sec_d;
      ivl_q <= ivl_d;
    end
  end

  assign tb.one_sec_tick = (sec_q == SEC_LAST);
  assign tb.short_tick   = (ivl_q >= ivl_last);

  a_short_period: assert property (@(posedge clock) disable iff (srst)
    tb.short_tick && !tb.e1_mode |=> ivl_q == '0)
    else $error("short interval counter did not restart");
  a_e1_length: assert property (@(posedge clock) disable iff (srst)
    tb.short_tick && tb.e1_mode && $stable(tb.e1_mode)
      |-> ivl_q == E1_LAST)
    else $error("e1 short interval has wrong length");
endmodule
